// ---- src/lcd_drive_cfg.svh ----
// Constants for the LCD multiplex drive timing block
`ifndef LCD_DRIVE_CFG_SVH
`define LCD_DRIVE_CFG_SVH

`define SEG_COUNT 60
`define BP_COUNT 4
`define OSC_CNT_W 24
`define HALF_CNT_W 4

// Frame rate and the fixed division of the LCD clock
`define FRAME_HZ 64
`define FRAME_DIV 24

// LCD clocks per half bit-phase, i.e. FRAME_DIV / (2 * backplanes)
`define HALF_LEN_STATIC 4'hc
`define HALF_LEN_MUX2 4'h6
`define HALF_LEN_MUX3 4'h4
`define HALF_LEN_MUX4 4'h3

// Drive mode codes on the mode command
`define MODE_CODE_STATIC 2'h1
`define MODE_CODE_MUX2 2'h2
`define MODE_CODE_MUX3 2'h3
`define MODE_CODE_MUX4 2'h0

// Output level codes: ground, lower tap, upper tap, LCD supply
`define LVL_VSS 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_VLCD 2'h3

// Reset values
`define RST_HALF_BIAS 1'b0
`define RST_ENABLE 1'b0
`define RST_SYNC_IDLE 1'b1

`endif

// ---- src/lcd_drive_pkg.sv ----
// Types for the LCD multiplex drive timing block
`include "lcd_drive_cfg.svh"

package lcd_drive_pkg;

   typedef enum logic [1:0] {
      DRIVE_STATIC,
      DRIVE_MUX2,
      DRIVE_MUX3,
      DRIVE_MUX4
   } drive_t;

   typedef logic [1:0] level_t;

   typedef struct packed {
      logic sel_s1;
      logic sel_s2;
      logic ck_s1;
      logic ck_s2;
      logic ck_d;
      logic sy_s1;
      logic sy_s2;
      logic sy_d;
      logic [`OSC_CNT_W-1:0] osc_cnt;
      logic clk_out;
      drive_t drive;
      logic half_bias;
      logic enable;
      logic [1:0] bit_sel;
      logic pol;
      logic load_pend;
      logic sync_drive;
      logic [`SEG_COUNT-1:0] latch;
      logic [2*`BP_COUNT-1:0] bp_lvl;
      logic [2*`SEG_COUNT-1:0] seg_lvl;
   } drive_state_t;

   typedef struct packed {
      logic [`HALF_CNT_W-1:0] cnt;
   } div_state_t;

endpackage : lcd_drive_pkg

// ---- src/lcd_frame_divider.sv ----
// Half bit-phase divider of the selected LCD clock
`timescale 1ns/1ps
`include "lcd_drive_cfg.svh"

module lcd_frame_divider (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_tick,
   input wire logic i_restart,
   input wire logic [`HALF_CNT_W-1:0] i_half_len,
   output logic o_half_end
);

   lcd_drive_pkg::div_state_t s_reg;
   lcd_drive_pkg::div_state_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   // Fixed integer division, restartable by alignment
   assign o_half_end = i_tick && !i_restart && (s_reg.cnt == i_half_len - 4'h1);

   always_comb begin
      s_next = s_reg;
      if (i_restart) begin
         s_next.cnt = '0;
      end else if (o_half_end) begin
         s_next.cnt = '0;
      end else if (i_tick) begin
         s_next.cnt = s_reg.cnt + 4'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule : lcd_frame_divider

// ---- src/lcd_multiplex_drive_timing.sv ----
// LCD multiplex drive timing, cascade alignment and output level generation
//
// Summary of operation
// - Report half bias to the bias network
// - Latest mode command steers the multiplexing
// - Static mode: one backplane, two levels
// - Two-backplane mode offers half or third bias
// - Three-backplane multiplex mode provided
// - Four-backplane multiplex mode provided
// - Half bias allowed with three, four backplanes
// - One selected clock times all drive logic
// - Select low: internal oscillator, driven out
// - Select high: clock pin is the input
// - Frame is fixed division of selected clock
// - Timing schedules RAM column into latch
// - Cascaded devices share alignment pulse line
// - Latch holds one RAM column per phase
// - Sixty segments from latch and phase
// - Four backplanes shaped by drive mode
// - Three-backplane mode: backplane 3 copies 1
// - Two-backplane mode: 0 with 2, 1 with 3
// - Static mode: all backplanes identical
// - Frame equals selected clock divided by 24
// - Alignment pulse restarts at last bit
// - Column k against backplane k, ascending order
// - Reset: four-backplane, third bias, display off
`timescale 1ns/1ps
`include "lcd_drive_cfg.svh"

module lcd_multiplex_drive_timing #(
   parameter int CLK_HZ = 250_000_000,
   parameter int OSC_CYCLES = CLK_HZ / (`FRAME_HZ * `FRAME_DIV)
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_oscillator_source_select_pin,
   input wire logic i_clk_pin,
   output logic o_clk_pin,
   output logic o_clk_pin_oe,
   input wire logic i_sync_n,
   output logic o_sync_n,
   output logic o_sync_n_oe,
   input wire logic i_mode_valid,
   input wire logic [1:0] i_mode_drive,
   input wire logic i_mode_half_bias,
   input wire logic i_mode_enable,
   output logic [1:0] o_ram_bit_sel,
   input wire logic [`SEG_COUNT-1:0] i_ram_column,
   output logic o_half_bias,
   output logic [1:0] o_backplane_out_0,
   output logic [1:0] o_backplane_out_1,
   output logic [1:0] o_backplane_out_2,
   output logic [1:0] o_backplane_out_3,
   output logic [2*`SEG_COUNT-1:0] o_segment_outputs
);

   localparam logic [`OSC_CNT_W-1:0] OSC_LAST = (`OSC_CNT_W)'(OSC_CYCLES - 1);
   localparam logic [`OSC_CNT_W-1:0] OSC_HALF = (`OSC_CNT_W)'(OSC_CYCLES / 2);

   // Too short a period or too narrow a counter breaks the tick
   if (OSC_CYCLES < 2 || OSC_CYCLES >= (1 << `OSC_CNT_W)) begin : g_osc_check
      $error("OSC_CYCLES out of range for the oscillator counter");
   end

   lcd_drive_pkg::drive_state_t s_reg;
   lcd_drive_pkg::drive_state_t s_next;

   logic lcd_tick;
   logic sync_fall;
   logic restart;
   logic half_end;
   logic [`HALF_CNT_W-1:0] half_len;
   logic [1:0] last_bit;
   logic [`SEG_COUNT-1:0] cur_data;
   logic [2*`BP_COUNT-1:0] bp_lvl;
   logic [2*`SEG_COUNT-1:0] seg_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic lcd_drive_pkg::drive_t decode_drive(input logic [1:0] code);
      lcd_drive_pkg::drive_t d;
      d = lcd_drive_pkg::DRIVE_MUX4;
      unique case (code)
         `MODE_CODE_STATIC: d = lcd_drive_pkg::DRIVE_STATIC;
         `MODE_CODE_MUX2: d = lcd_drive_pkg::DRIVE_MUX2;
         `MODE_CODE_MUX3: d = lcd_drive_pkg::DRIVE_MUX3;
         `MODE_CODE_MUX4: d = lcd_drive_pkg::DRIVE_MUX4;
      endcase
      return d;
   endfunction : decode_drive

   // Physical backplane level for the current bit phase and polarity
   function automatic lcd_drive_pkg::level_t bp_level(
      input lcd_drive_pkg::drive_t d,
      input logic [1:0] b,
      input logic p,
      input logic [1:0] k
   );
      logic [1:0] lg;
      lcd_drive_pkg::level_t lv;
      lg = k;
      unique case (d)
         lcd_drive_pkg::DRIVE_STATIC: lg = b;
         lcd_drive_pkg::DRIVE_MUX2: lg = {1'b0, k[0]};
         lcd_drive_pkg::DRIVE_MUX3: lg = (k == 2'h3) ? 2'h1 : k;
         lcd_drive_pkg::DRIVE_MUX4: lg = k;
      endcase
      if (lg == b) begin
         lv = p ? `LVL_VSS : `LVL_VLCD;
      end else begin
         lv = p ? `LVL_HIGH : `LVL_LOW;
      end
      return lv;
   endfunction : bp_level

   // Half bias shorts the taps, so off segments then use ground and supply, as in static mode
   function automatic lcd_drive_pkg::level_t seg_level(
      input lcd_drive_pkg::drive_t d,
      input logic hb,
      input logic p,
      input logic on
   );
      lcd_drive_pkg::level_t lv;
      if (on) begin
         lv = p ? `LVL_VLCD : `LVL_VSS;
      end else if (d == lcd_drive_pkg::DRIVE_STATIC || hb) begin
         lv = p ? `LVL_VSS : `LVL_VLCD;
      end else begin
         lv = p ? `LVL_LOW : `LVL_HIGH;
      end
      return lv;
   endfunction : seg_level

   ////////////////////////////////////////////////////////////////////////////
   // Mode dependent lengths

   always_comb begin
      half_len = `HALF_LEN_MUX4;
      last_bit = 2'h3;
      unique case (s_reg.drive)
         lcd_drive_pkg::DRIVE_STATIC: begin
            half_len = `HALF_LEN_STATIC;
            last_bit = 2'h0;
         end
         lcd_drive_pkg::DRIVE_MUX2: begin
            half_len = `HALF_LEN_MUX2;
            last_bit = 2'h1;
         end
         lcd_drive_pkg::DRIVE_MUX3: begin
            half_len = `HALF_LEN_MUX3;
            last_bit = 2'h2;
         end
         lcd_drive_pkg::DRIVE_MUX4: begin
            half_len = `HALF_LEN_MUX4;
            last_bit = 2'h3;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock source

   assign lcd_tick = s_reg.sel_s2 ? (s_reg.ck_s2 && !s_reg.ck_d)
                                  : (s_reg.osc_cnt == OSC_LAST);

   // Own pulse is not taken as a restart, or it would restart itself forever
   assign sync_fall = s_reg.sy_d && !s_reg.sy_s2 && !s_reg.sync_drive;
   assign restart = i_mode_valid || sync_fall;

   lcd_frame_divider u_divider (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tick(lcd_tick),
      .i_restart(restart),
      .i_half_len(half_len),
      .o_half_end(half_end)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Per output level generation

   assign cur_data = s_reg.load_pend ? i_ram_column : s_reg.latch;

   genvar gi;
   generate
      for (gi = 0; gi < `BP_COUNT; gi++) begin : g_bp
         assign bp_lvl[2*gi +: 2] = bp_level(s_reg.drive, s_reg.bit_sel, s_reg.pol,
                                             2'(gi));
      end
      for (gi = 0; gi < `SEG_COUNT; gi++) begin : g_seg
         assign seg_lvl[2*gi +: 2] = seg_level(s_reg.drive, s_reg.half_bias,
                                               s_reg.pol, cur_data[gi]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next = s_reg;
      s_next.sel_s1 = i_oscillator_source_select_pin;
      s_next.sel_s2 = s_reg.sel_s1;
      s_next.ck_s1 = i_clk_pin;
      s_next.ck_s2 = s_reg.ck_s1;
      s_next.ck_d = s_reg.ck_s2;
      s_next.sy_s1 = i_sync_n;
      s_next.sy_s2 = s_reg.sy_s1;
      s_next.sy_d = s_reg.sy_s2;

      if (s_reg.sel_s2 || s_reg.osc_cnt == OSC_LAST) begin
         s_next.osc_cnt = '0;
      end else begin
         s_next.osc_cnt = s_reg.osc_cnt + 24'h1;
      end
      s_next.clk_out = !s_reg.sel_s2 && (s_reg.osc_cnt < OSC_HALF);

      s_next.load_pend = 1'b0;
      if (s_reg.load_pend) begin
         s_next.latch = i_ram_column;
      end

      if (i_mode_valid) begin
         s_next.drive = decode_drive(i_mode_drive);
         s_next.half_bias = i_mode_half_bias;
         s_next.enable = i_mode_enable;
         s_next.bit_sel = 2'h0;
         s_next.pol = 1'b0;
         s_next.load_pend = 1'b1;
      end else if (sync_fall) begin
         s_next.bit_sel = last_bit;
         s_next.pol = 1'b0;
         s_next.load_pend = 1'b1;
      end else if (half_end) begin
         s_next.pol = !s_reg.pol;
         if (s_reg.pol) begin
            s_next.bit_sel = (s_reg.bit_sel == last_bit) ? 2'h0 : s_reg.bit_sel + 2'h1;
            s_next.load_pend = 1'b1;
         end
      end

      s_next.sync_drive = (s_reg.bit_sel == last_bit) && !s_reg.pol;

      if (s_reg.enable) begin
         s_next.bp_lvl = bp_lvl;
         s_next.seg_lvl = seg_lvl;
      end else begin
         s_next.bp_lvl = {`BP_COUNT{`LVL_VLCD}};
         s_next.seg_lvl = {`SEG_COUNT{`LVL_VLCD}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
         s_reg.sy_s1 <= `RST_SYNC_IDLE;
         s_reg.sy_s2 <= `RST_SYNC_IDLE;
         s_reg.sy_d <= `RST_SYNC_IDLE;
         s_reg.drive <= lcd_drive_pkg::DRIVE_MUX4;
         s_reg.half_bias <= `RST_HALF_BIAS;
         s_reg.enable <= `RST_ENABLE;
         s_reg.bp_lvl <= {`BP_COUNT{`LVL_VLCD}};
         s_reg.seg_lvl <= {`SEG_COUNT{`LVL_VLCD}};
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_clk_pin = s_reg.clk_out;
   assign o_clk_pin_oe = !s_reg.sel_s2;
   assign o_sync_n = 1'b0;
   assign o_sync_n_oe = s_reg.sync_drive;
   assign o_ram_bit_sel = s_reg.bit_sel;
   assign o_half_bias = s_reg.half_bias;
   assign o_backplane_out_0 = s_reg.bp_lvl[1:0];
   assign o_backplane_out_1 = s_reg.bp_lvl[3:2];
   assign o_backplane_out_2 = s_reg.bp_lvl[5:4];
   assign o_backplane_out_3 = s_reg.bp_lvl[7:6];
   assign o_segment_outputs = s_reg.seg_lvl;

endmodule : lcd_multiplex_drive_timing

// ---- testbench/lcd_drive_timing_sva.sv ----
// Assertion checker for the LCD multiplex drive timing block
`timescale 1ns/1ps
`include "lcd_drive_cfg.svh"

module lcd_drive_timing_sva (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_oscillator_source_select_pin,
   input wire logic i_mode_valid,
   input wire logic [1:0] i_mode_drive,
   input wire logic i_mode_half_bias,
   input wire logic i_mode_enable,
   input wire logic o_clk_pin_oe,
   input wire logic o_sync_n_oe,
   input wire logic [1:0] o_ram_bit_sel,
   input wire logic o_half_bias,
   input wire logic [1:0] o_backplane_out_0,
   input wire logic [1:0] o_backplane_out_1,
   input wire logic [1:0] o_backplane_out_2,
   input wire logic [1:0] o_backplane_out_3,
   input wire logic [2*`SEG_COUNT-1:0] o_segment_outputs
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////
   // Last command seen; age saturates so outputs are trusted late
   logic [1:0] mode_reg;
   logic en_reg;
   logic [1:0] age_reg;
   logic settled;
   logic [1:0] last_bit;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_reg <= `MODE_CODE_MUX4;
         en_reg <= `RST_ENABLE;
         age_reg <= 2'h3;
      end else if (i_mode_valid) begin
         mode_reg <= i_mode_drive;
         en_reg <= i_mode_enable;
         age_reg <= 2'h0;
      end else if (age_reg != 2'h3) begin
         age_reg <= age_reg + 2'h1;
      end
   end
   assign settled = (age_reg == 2'h3);
   // Mode codes are spaced so that last bit is code minus one
   assign last_bit = mode_reg - 2'h1;
   ////////////////////////////////////////////////////////////////
   property p_clk_int; (!i_oscillator_source_select_pin)[*5] |-> o_clk_pin_oe; endproperty
   a_clk_int: assert property (p_clk_int) else $error("clock pin not driven");
   property p_clk_ext; i_oscillator_source_select_pin[*5] |-> !o_clk_pin_oe; endproperty
   a_clk_ext: assert property (p_clk_ext) else $error("clock pin still driven");
   property p_bias;
      i_mode_valid && i_mode_drive != `MODE_CODE_STATIC |=> o_half_bias == $past(i_mode_half_bias);
   endproperty
   a_bias: assert property (p_bias) else $error("half bias not taken");
   property p_restart; i_mode_valid |=> o_ram_bit_sel == 2'h0; endproperty
   a_restart: assert property (p_restart) else $error("mode did not restart at bit 0");
   property p_static;
      settled && mode_reg == `MODE_CODE_STATIC |-> o_backplane_out_0 == o_backplane_out_1
         && o_backplane_out_1 == o_backplane_out_2 && o_backplane_out_2 == o_backplane_out_3;
   endproperty
   a_static: assert property (p_static) else $error("static backplanes differ");
   property p_mux2;
      settled && mode_reg == `MODE_CODE_MUX2 |-> o_backplane_out_0 == o_backplane_out_2
         && o_backplane_out_1 == o_backplane_out_3;
   endproperty
   a_mux2: assert property (p_mux2) else $error("two backplane pairs differ");
   property p_mux3; settled && mode_reg == `MODE_CODE_MUX3 |-> o_backplane_out_3 == o_backplane_out_1;
   endproperty
   a_mux3: assert property (p_mux3) else $error("backplane 3 differs from 1");
   property p_off;
      settled && !en_reg |-> o_backplane_out_0 == `LVL_VLCD && o_backplane_out_3 == `LVL_VLCD
         && o_segment_outputs == {`SEG_COUNT{`LVL_VLCD}};
   endproperty
   a_off: assert property (p_off) else $error("disabled outputs not at supply");
   property p_sync; settled && o_sync_n_oe |-> $past(o_ram_bit_sel) == last_bit; endproperty
   a_sync: assert property (p_sync) else $error("sync pulse outside last bit");
endmodule : lcd_drive_timing_sva

bind lcd_multiplex_drive_timing lcd_drive_timing_sva i_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_oscillator_source_select_pin(i_oscillator_source_select_pin), .i_mode_valid(i_mode_valid),
   .i_mode_drive(i_mode_drive), .i_mode_half_bias(i_mode_half_bias),
   .i_mode_enable(i_mode_enable), .o_clk_pin_oe(o_clk_pin_oe), .o_sync_n_oe(o_sync_n_oe),
   .o_ram_bit_sel(o_ram_bit_sel), .o_half_bias(o_half_bias),
   .o_backplane_out_0(o_backplane_out_0), .o_backplane_out_1(o_backplane_out_1),
   .o_backplane_out_2(o_backplane_out_2), .o_backplane_out_3(o_backplane_out_3),
   .o_segment_outputs(o_segment_outputs));

// ---- testbench/lcd_glass_panel.sv ----
// Behavioural glass panel watching segment 0 against each backplane
`timescale 1ns/1ps

module lcd_glass_panel (
   input wire logic i_clk,
   input wire logic i_clr,
   input wire logic [7:0] i_bp,
   input wire logic [1:0] i_seg,
   output logic [3:0] o_seen,
   output int o_dc
);
   int diff;
   always @(posedge i_clk) begin
      if (i_clr) begin
         o_seen <= 4'h0;
         o_dc <= 0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            diff = int'(i_seg) - int'(i_bp[2*k +: 2]);
            // Full swing lights a pixel
            if (diff == 3 || diff == -3) o_seen[k] <= 1'b1;
            // Net charge on pixel 0, must cancel per frame
            if (k == 0) o_dc <= o_dc + diff;
         end
      end
   end
endmodule : lcd_glass_panel

// ---- testbench/lcd_multiplex_drive_timing_bench.sv ----
// Self-checking bench for the LCD multiplex drive timing block
`timescale 1ns/1ps
`include "lcd_drive_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end

module lcd_multiplex_drive_timing_bench;
   typedef struct packed {
      logic [1:0] code;
      logic hb;
      logic [3:0] bits;
      logic [3:0] mask;
   } row_t;
   // Code, half bias, RAM bits of segment 0, lit backplanes
   localparam row_t ROWS [8] = '{
      '{2'h1, 1'b0, 4'h1, 4'hf}, '{2'h1, 1'b0, 4'he, 4'h0},
      '{2'h2, 1'b1, 4'h2, 4'ha}, '{2'h2, 1'b0, 4'h1, 4'h5},
      '{2'h3, 1'b0, 4'h2, 4'ha}, '{2'h3, 1'b1, 4'h4, 4'h4},
      '{2'h0, 1'b0, 4'h9, 4'h9}, '{2'h0, 1'b1, 4'h6, 4'h6}};
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic sel = 1'b0, pull = 1'b0, mv = 1'b0, mh = 1'b0, me = 1'b0, clr = 1'b0;
   logic [1:0] md = 2'h0;
   logic [2:0] ext_cnt = 3'h0;
   logic [`SEG_COUNT-1:0] ram [4] = '{default: '0};
   logic clk_o, clk_oe, sync_o, sync_oe, hb;
   logic [1:0] bit_sel, bp0, bp1, bp2, bp3;
   logic [2*`SEG_COUNT-1:0] seg;
   logic [3:0] seen;
   int dc;
   localparam int OSC = 4;
   int clk_edges = 0;
   int miscompares = 0;
   int total_checks = 0;
   // Shared pins resolved from every party's enable
   wire clk_line = clk_oe ? clk_o : ext_cnt[2];
   wire sync_line = ~((sync_oe & ~sync_o) | pull);
   ////////////////////////////////////////////////////////////////
   lcd_multiplex_drive_timing #(.OSC_CYCLES(OSC)) i_dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_oscillator_source_select_pin(sel),
      .i_clk_pin(clk_line), .o_clk_pin(clk_o), .o_clk_pin_oe(clk_oe),
      .i_sync_n(sync_line), .o_sync_n(sync_o), .o_sync_n_oe(sync_oe),
      .i_mode_valid(mv), .i_mode_drive(md), .i_mode_half_bias(mh), .i_mode_enable(me),
      .o_ram_bit_sel(bit_sel), .i_ram_column(ram[bit_sel]), .o_half_bias(hb),
      .o_backplane_out_0(bp0), .o_backplane_out_1(bp1), .o_backplane_out_2(bp2),
      .o_backplane_out_3(bp3), .o_segment_outputs(seg));
   lcd_glass_panel i_panel (.i_clk(i_clk), .i_clr(clr), .i_bp({bp3, bp2, bp1, bp0}),
      .i_seg(seg[1:0]), .o_seen(seen), .o_dc(dc));
   ////////////////////////////////////////////////////////////////
   // Clock never stops, else the glass sees DC
   initial begin
      forever #2 i_clk = ~i_clk;
   end
   always @(negedge i_clk) ext_cnt <= ext_cnt + 3'h1;
   always @(posedge clk_o) clk_edges <= clk_edges + 1;
   task automatic set_mode(input logic [1:0] code, input logic h, input logic en);
      @(negedge i_clk);
      mv = 1'b1; md = code; mh = h; me = en;
      @(negedge i_clk);
      mv = 1'b0;
   endtask : set_mode
   task automatic do_row(input row_t r, input int n);
      int e0;
      for (int k = 0; k < 4; k++) ram[k] = {`SEG_COUNT{r.bits[k]}};
      set_mode(r.code, r.hb, 1'b1);
      repeat (8) @(negedge i_clk);
      @(negedge i_clk);
      clr = 1'b1;
      @(negedge i_clk);
      clr = 1'b0;
      e0 = clk_edges;
      repeat (n) @(negedge i_clk);
      `CHK(hb, r.hb)
      `CHK(seen, r.mask)
      `CHK(dc, 0)
      `CHK(seg, {`SEG_COUNT{seg[1:0]}})
      `CHK(clk_edges - e0, sel ? 0 : n / OSC)
   endtask : do_row
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////
   initial begin
      // Serial host bus lies outside this block
      repeat (4) @(negedge i_clk);
      `CHK(bp0, 2'h3)
      `CHK(hb, 1'b0)
      `CHK(clk_oe, 1'b1)
      `CHK(sync_oe, 1'b0)
      `CHK(sync_o, 1'b0)
      i_rst_n = 1'b1;
      repeat (6) @(negedge i_clk);
      `CHK(seg, {`SEG_COUNT{2'h3}})
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         do_row(ROWS[i], 96);
         $display("row %0d done", i);
      end
      set_mode(2'h0, 1'b0, 1'b0);
      repeat (3) @(negedge i_clk);
      `CHK(bp1, 2'h3)
      `CHK(seg, {`SEG_COUNT{2'h3}})
      $display("disable test done");
      // Pulse arrives in bit 0, well before the own pulse except in static mode, where bit 0 is the last bit
      for (int k = 0; k < 4; k++) begin
         set_mode(2'(k), 1'b1, 1'b1);
         repeat (10) @(negedge i_clk);
         pull = 1'b1;
         repeat (2) @(negedge i_clk);
         pull = 1'b0;
         repeat (4) @(negedge i_clk);
         `CHK(bit_sel, 2'(k - 1))
         `CHK(sync_oe, 1'b1)
      end
      $display("sync test done");
      // Mid-run reset drops half bias, back to four backplanes
      i_rst_n = 1'b0;
      repeat (4) @(negedge i_clk);
      `CHK(hb, 1'b0)
      `CHK(bp2, 2'h3)
      i_rst_n = 1'b1;
      repeat (10) @(negedge i_clk);
      pull = 1'b1;
      repeat (2) @(negedge i_clk);
      pull = 1'b0;
      repeat (4) @(negedge i_clk);
      `CHK(bit_sel, 2'h3)
      $display("mid-run reset test done");
      sel = 1'b1;
      repeat (8) @(negedge i_clk);
      `CHK(clk_oe, 1'b0)
      do_row(ROWS[6], 192);
      $display("external clock test done");
      end_of_test();
   end
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
endmodule : lcd_multiplex_drive_timing_bench
